// *** rtl/tbr_router.sv ***
/*
 Trigger bus and timebase router: seven two-way shared trigger lines,
 a bus clock line, timebase select, digital trigger select, DMA channel
 bookkeeping and interrupt-mode data request.
 Assumes pins arrive asynchronously; an APB master on clk_i.
*/
// Function
// (RL1) Seven shared trigger lines serve every device on the bus.
// (RL2) Each shared trigger line can drive out or receive a signal.
// (RL3) On backplane, shared lines 0 to 5 map to backplane lines 0 to 5.
// (RL4) On backplane, shared line 6 connects to the star trigger line.
// (RL5) Master timebase is internal reference or received bus timebase.
// (RL6) Timebase crosses only on line seven, the bus clock line.
// (RL7) Selected timebase feeds all timing generation in the device.
// (RL8) With internal timebase, device may drive it onto bus clock line.
// (RL9) Reset selects internal timebase with bus clock driver off.
// (RL10) Slaves take timebase over line seven, triggers over free lines.
// (RL11) Controller starts all slaves before starting the master.
// (RL12) Trigger source is any input function pin or shared line 0..6.
// (RL13) Trigger fires on selected rising or falling edge.
// (RL14) Detected trigger acts on AI, AO or counters as configured.
// (RL15) Request for DMA when all channels are taken fails with error.
// (RL16) Interrupt mode raises a request when data is ready to move.
// (RL17) DMA is the default transfer mechanism.
// (RL18) Without backplane trigger extensions the shared bus is disabled.
// (RL19) Each input function pin has own polarity and edge/level mode.
// (RL20) External inputs pass two flops before edge detection.
`timescale 1ns/100ps
module tbr_router (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [tbr_pkg::TBR_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Shared trigger lines
    input wire logic [tbr_pkg::TBR_TRIG_LINES-1:0] trig_line_i,
    output logic [tbr_pkg::TBR_TRIG_LINES-1:0] trig_line_o,
    output logic [tbr_pkg::TBR_TRIG_LINES-1:0] trig_line_oe_o,
    // Bus clock line and timebases
    input wire logic bus_clk_i,
    output logic bus_clk_o,
    output logic bus_clk_oe_o,
    input wire logic internal_reference_timebase_i,
    output logic master_timebase_o,
    // Backplane presence strap
    input wire logic backplane_present_i,
    // Function pins and internal timing sources
    input wire logic [tbr_pkg::TBR_PFI_PINS-1:0] pfi_i,
    input wire logic [tbr_pkg::TBR_TRIG_LINES-1:0] internal_timing_i,
    // Trigger actions
    output logic ai_trig_o,
    output logic ao_trig_o,
    output logic ctr_trig_o,
    // Data transfer
    input wire logic data_ready_i,
    output logic irq_o,
    output logic [tbr_pkg::TBR_DMA_CHANS-1:0] dma_alloc_o
);
    import tbr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        tbr_apb_e apb;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        tbr_tb_e tb_sel;
        logic clk_drv;
        logic [TBR_TRIG_LINES-1:0] drive_en;
        logic [TBR_SRC_W-1:0] trg_src;
        tbr_edge_e trg_edge;
        logic [2:0] trg_act;
        logic [TBR_PFI_PINS-1:0] pfi_pol;
        logic [TBR_PFI_PINS-1:0] pfi_level;
        logic [TBR_DMA_CHANS-1:0] dma_used;
        logic dma_err;
        logic trig_seen;
        logic irq_mode;
        logic bkp;
        logic [TBR_TRIG_LINES-1:0] line_s1;
        logic [TBR_TRIG_LINES-1:0] line_s2;
        logic [TBR_PFI_PINS-1:0] pfi_s1;
        logic [TBR_PFI_PINS-1:0] pfi_s2;
        logic [1:0] bclk_s;
        logic [1:0] iclk_s;
        logic [1:0] bkp_s;
        logic src_prev;
        logic [TBR_TRIG_LINES-1:0] line_o;
        logic [TBR_TRIG_LINES-1:0] line_oe;
        logic bclk_o;
        logic bclk_oe;
        logic mtb;
        logic ai;
        logic ao;
        logic ctr;
        logic irq;
    } tbr_state_s;

    tbr_state_s st;
    tbr_state_s next_st;

    // Picks the trigger source: pins first, then shared lines 0..6.
    function automatic logic pick_src(
        input logic [TBR_SRC_W-1:0] sel,
        input logic [TBR_PFI_PINS-1:0] pins,
        input logic [TBR_TRIG_LINES-1:0] lines
    );
        logic r;
        r = 1'b0;
        if (sel < TBR_SRC_W'(TBR_PFI_PINS)) begin
            r = pins[sel[3:0]]; // RL12
        end else if (sel < TBR_SRC_W'(TBR_PFI_PINS + TBR_TRIG_LINES)) begin
            r = lines[3'(sel - TBR_SRC_W'(TBR_PFI_PINS))]; // RL12
        end
        return r;
    endfunction

    // Lowest free DMA channel, one-hot; zero when all are taken.
    function automatic logic [TBR_DMA_CHANS-1:0] first_free(
        input logic [TBR_DMA_CHANS-1:0] used
    );
        logic [TBR_DMA_CHANS-1:0] f;
        f = '0;
        for (int i = TBR_DMA_CHANS - 1; i >= 0; i--) begin
            if (!used[i]) begin
                f = '0;
                f[i] = 1'b1;
            end
        end
        return f;
    endfunction

    logic [TBR_PFI_PINS-1:0] pfi_eff;
    logic [TBR_TRIG_LINES-1:0] line_rx;
    logic src_now;
    logic hit;
    logic lvl_src;
    logic [TBR_DMA_CHANS-1:0] free_ch;
    logic wr;
    logic rd;

    always_comb begin
        next_st = st;
        // ------------------------------------------------------------
        // Input synchronisers; stage one feeds only stage two.
        // ------------------------------------------------------------
        next_st.line_s1 = trig_line_i; // RL20
        next_st.line_s2 = st.line_s1; // RL20
        next_st.pfi_s1 = pfi_i; // RL20
        next_st.pfi_s2 = st.pfi_s1; // RL20
        next_st.bclk_s = {st.bclk_s[0], bus_clk_i};
        next_st.iclk_s = {st.iclk_s[0], internal_reference_timebase_i};
        next_st.bkp_s = {st.bkp_s[0], backplane_present_i};
        next_st.bkp = st.bkp_s[1];

        // Receive only lines not driven by us; all gated without backplane.
        line_rx = st.bkp ? (st.line_s2 & ~st.line_oe) : '0; // RL2 RL18
        pfi_eff = st.pfi_s2 ^ st.pfi_pol; // RL19

        // ------------------------------------------------------------
        // Trigger detection
        // ------------------------------------------------------------
        src_now = pick_src(st.trg_src, pfi_eff, line_rx);
        lvl_src = (st.trg_src < TBR_SRC_W'(TBR_PFI_PINS))
            && st.pfi_level[st.trg_src[3:0]];
        next_st.src_prev = src_now;
        if (lvl_src) begin
            hit = src_now; // RL19
        end else if (st.trg_edge == TBR_EDGE_RISE) begin
            hit = src_now && !st.src_prev; // RL13
        end else begin
            hit = !src_now && st.src_prev; // RL13
        end
        next_st.ai = hit && st.trg_act[0]; // RL14
        next_st.ao = hit && st.trg_act[1]; // RL14
        next_st.ctr = hit && st.trg_act[2]; // RL14

        // ------------------------------------------------------------
        // Timebase and shared line drivers
        // ------------------------------------------------------------
        next_st.mtb = (st.tb_sel == TBR_TB_BUS) ? st.bclk_s[1]
            : st.iclk_s[1]; // RL5 RL6 RL7
        next_st.bclk_o = st.iclk_s[1]; // RL6
        next_st.bclk_oe = st.clk_drv && st.bkp
            && (st.tb_sel == TBR_TB_INTERNAL); // RL8
        // Lines 0..5 go to backplane lines, 6 to the star line, same order.
        next_st.line_o = internal_timing_i; // RL1 RL3 RL4
        next_st.line_oe = st.bkp ? st.drive_en : '0; // RL2 RL18

        // ------------------------------------------------------------
        // Transfer request
        // ------------------------------------------------------------
        next_st.irq = st.irq_mode && data_ready_i; // RL16

        // ------------------------------------------------------------
        // APB slave: one wait state, answer in the access phase.
        // ------------------------------------------------------------
        free_ch = first_free(st.dma_used);
        wr = 1'b0;
        rd = 1'b0;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        if (hit) begin
            next_st.trig_seen = 1'b1;
        end
        unique case (st.apb)
            TBR_APB_IDLE: begin
                if (psel_i && !penable_i) begin
                    next_st.apb = TBR_APB_SETUP;
                end
            end
            TBR_APB_SETUP: begin
                next_st.apb = TBR_APB_ACCESS;
                next_st.pready = 1'b1;
                wr = pwrite_i;
                rd = !pwrite_i;
            end
            TBR_APB_ACCESS: begin
                next_st.apb = (psel_i && !penable_i) ? TBR_APB_SETUP
                    : TBR_APB_IDLE;
            end
        endcase
        next_st.prdata = '0;
        if (wr) begin
            unique case (paddr_i)
                TBR_CLK_CTRL_OFS: begin
                    next_st.tb_sel = tbr_tb_e'(pwdata_i[TBR_CLK_SEL_BIT]);
                    next_st.clk_drv = pwdata_i[TBR_CLK_DRV_BIT];
                end
                TBR_BUS_DRIVE_OFS: next_st.drive_en = pwdata_i[6:0];
                TBR_TRIG_CTRL_OFS: begin
                    next_st.trg_src = pwdata_i[TBR_TRG_SRC_LSB +: 5];
                    next_st.trg_edge =
                        tbr_edge_e'(pwdata_i[TBR_TRG_EDGE_BIT]);
                    next_st.trg_act = pwdata_i[TBR_TRG_CTR_BIT:TBR_TRG_AI_BIT];
                end
                TBR_PFI_POL_OFS: next_st.pfi_pol = pwdata_i[9:0];
                TBR_PFI_LEVEL_OFS: next_st.pfi_level = pwdata_i[9:0];
                TBR_DMA_REQ_OFS: begin
                    // Refusal is flagged in pslverr and dma_err; the claim leaves dma_used untouched.
                    if (free_ch == '0) begin
                        next_st.pslverr = 1'b1; // RL15
                        next_st.dma_err = 1'b1; // RL15
                    end else begin
                        next_st.dma_used = st.dma_used | free_ch;
                    end
                end
                TBR_DMA_REL_OFS: begin
                    next_st.dma_used = st.dma_used & ~pwdata_i[1:0];
                end
                TBR_STATUS_OFS: begin
                    // Write one to clear; a new event in the same cycle wins.
                    if (pwdata_i[TBR_ST_DMA_ERR_BIT]) begin
                        next_st.dma_err = 1'b0;
                    end
                    if (pwdata_i[TBR_ST_TRIG_BIT] && !hit) begin
                        next_st.trig_seen = 1'b0;
                    end
                end
                TBR_XFER_OFS: begin
                    next_st.irq_mode = pwdata_i[TBR_XFER_IRQ_BIT]; // RL17
                end
                default: next_st.pslverr = 1'b1;
            endcase
        end
        if (rd) begin
            unique case (paddr_i)
                TBR_CLK_CTRL_OFS: begin
                    next_st.prdata[TBR_CLK_SEL_BIT] = st.tb_sel;
                    next_st.prdata[TBR_CLK_DRV_BIT] = st.clk_drv;
                    next_st.prdata[TBR_BKP_BIT] = st.bkp;
                    next_st.prdata[TBR_BUS_PRES_BIT] = st.bkp;
                end
                TBR_BUS_DRIVE_OFS: next_st.prdata[6:0] = st.drive_en;
                TBR_TRIG_CTRL_OFS: begin
                    next_st.prdata[TBR_TRG_SRC_LSB +: 5] = st.trg_src;
                    next_st.prdata[TBR_TRG_EDGE_BIT] = st.trg_edge;
                    next_st.prdata[TBR_TRG_CTR_BIT:TBR_TRG_AI_BIT] =
                        st.trg_act;
                end
                TBR_PFI_POL_OFS: next_st.prdata[9:0] = st.pfi_pol;
                TBR_PFI_LEVEL_OFS: next_st.prdata[9:0] = st.pfi_level;
                TBR_DMA_REQ_OFS: next_st.prdata[1:0] = st.dma_used;
                TBR_DMA_REL_OFS: next_st.prdata[1:0] = st.dma_used;
                TBR_STATUS_OFS: begin
                    next_st.prdata[1:0] = st.dma_used;
                    next_st.prdata[TBR_ST_DMA_ERR_BIT] = st.dma_err;
                    next_st.prdata[TBR_ST_TRIG_BIT] = st.trig_seen;
                end
                TBR_XFER_OFS: next_st.prdata[TBR_XFER_IRQ_BIT] = st.irq_mode;
                default: next_st.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st <= '0;
            st.tb_sel <= tbr_tb_e'(TBR_CLK_SEL_RST); // RL9
            st.clk_drv <= TBR_CLK_DRV_RST; // RL9
            st.irq_mode <= TBR_XFER_RST[TBR_XFER_IRQ_BIT]; // RL17
        end else begin
            st <= next_st;
        end
    end

    assign prdata_o = st.prdata;
    assign pready_o = st.pready;
    assign pslverr_o = st.pslverr;
    assign trig_line_o = st.line_o;
    assign trig_line_oe_o = st.line_oe;
    assign bus_clk_o = st.bclk_o;
    assign bus_clk_oe_o = st.bclk_oe;
    assign master_timebase_o = st.mtb;
    assign ai_trig_o = st.ai;
    assign ao_trig_o = st.ao;
    assign ctr_trig_o = st.ctr;
    assign irq_o = st.irq;
    assign dma_alloc_o = st.dma_used;
endmodule

// *** common/tbr_pkg.sv ***
/*
 Package for the trigger bus and timebase router: APB register map,
 field positions, reset values and enumerations.
 Assumes a 32-bit APB master on the same clock as the router.
*/
package tbr_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int TBR_TRIG_LINES = 7;
    localparam int TBR_PFI_PINS = 10;
    localparam int TBR_DMA_CHANS = 2;
    localparam int TBR_SRC_W = 5;
    localparam int TBR_ADDR_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TBR_CLK_CTRL_OFS = 8'h00;
    localparam logic [7:0] TBR_BUS_DRIVE_OFS = 8'h04;
    localparam logic [7:0] TBR_TRIG_CTRL_OFS = 8'h08;
    localparam logic [7:0] TBR_PFI_POL_OFS = 8'h0C;
    localparam logic [7:0] TBR_PFI_LEVEL_OFS = 8'h10;
    localparam logic [7:0] TBR_DMA_REQ_OFS = 8'h14;
    localparam logic [7:0] TBR_DMA_REL_OFS = 8'h18;
    localparam logic [7:0] TBR_STATUS_OFS = 8'h1C;
    localparam logic [7:0] TBR_XFER_OFS = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TBR_CLK_SEL_BIT = 0;
    localparam int TBR_CLK_DRV_BIT = 1;
    localparam int TBR_BKP_BIT = 2;
    localparam int TBR_BUS_PRES_BIT = 3;
    localparam int TBR_TRG_SRC_LSB = 0;
    localparam int TBR_TRG_EDGE_BIT = 8;
    localparam int TBR_TRG_AI_BIT = 9;
    localparam int TBR_TRG_AO_BIT = 10;
    localparam int TBR_TRG_CTR_BIT = 11;
    localparam int TBR_ST_DMA_ERR_BIT = 16;
    localparam int TBR_ST_TRIG_BIT = 17;
    localparam int TBR_XFER_IRQ_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic TBR_CLK_SEL_RST = 1'b0;
    localparam logic TBR_CLK_DRV_RST = 1'b0;
    localparam logic [31:0] TBR_TRIG_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] TBR_XFER_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic {
        TBR_TB_INTERNAL,
        TBR_TB_BUS
    } tbr_tb_e;

    typedef enum logic {
        TBR_EDGE_RISE,
        TBR_EDGE_FALL
    } tbr_edge_e;

    typedef enum logic [1:0] {
        TBR_APB_IDLE,
        TBR_APB_SETUP,
        TBR_APB_ACCESS
    } tbr_apb_e;
endpackage

// *** dv/tbr_router_properties.sv ***
/*
 Concurrent checks on the ports of the trigger bus and timebase router.
 Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/100ps
module tbr_router_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [tbr_pkg::TBR_ADDR_W-1:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Lines and transfers
    input wire logic [tbr_pkg::TBR_TRIG_LINES-1:0] internal_timing_i,
    input wire logic [tbr_pkg::TBR_TRIG_LINES-1:0] trig_line_o,
    input wire logic [tbr_pkg::TBR_TRIG_LINES-1:0] trig_line_oe_o,
    input wire logic bus_clk_oe_o,
    input wire logic backplane_present_i,
    input wire logic data_ready_i,
    input wire logic irq_o,
    input wire logic [tbr_pkg::TBR_DMA_CHANS-1:0] dma_alloc_o
);
    import tbr_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    sequence s_access;
        psel_i && $rose(penable_i);
    endsequence
    sequence s_one_wait;
        !pready_o ##1 pready_o;
    endsequence
    a_one_wait: assert property (s_access |-> s_one_wait)
        else $error("Ready did not follow one wait state.");
    a_refuse_full: assert property (s_access and (pwrite_i &&
        paddr_i == TBR_DMA_REQ_OFS && dma_alloc_o == 2'b11)
        |-> ##1 (pready_o && pslverr_o))
        else $error("Claim with all channels used was not refused.");
    a_refuse_keep: assert property (pready_o && pslverr_o
        |-> $stable(dma_alloc_o) [*3])
        else $error("Refused access changed the channel bits.");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("Error response without ready.");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("Ready stood longer than one cycle.");
    a_reset_quiet: assert property ($past(srst_i) |-> !bus_clk_oe_o &&
        dma_alloc_o == 2'b00 && !irq_o && trig_line_oe_o == 7'h00)
        else $error("Outputs not quiet after reset.");
    a_bkp_drive: assert property (!backplane_present_i [*5]
        |-> trig_line_oe_o == 7'h00 && !bus_clk_oe_o)
        else $error("Drivers enabled without backplane.");
    a_line_copy: assert property (!$past(srst_i)
        |-> trig_line_o == $past(internal_timing_i))
        else $error("Line output is not last cycle's internal timing.");
    a_irq_level: assert property (irq_o |-> $past(data_ready_i))
        else $error("Interrupt request without data ready.");
endmodule
bind tbr_router tbr_router_props u_props (
    .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .internal_timing_i(internal_timing_i), .trig_line_o(trig_line_o),
    .trig_line_oe_o(trig_line_oe_o), .bus_clk_oe_o(bus_clk_oe_o),
    .backplane_present_i(backplane_present_i),
    .data_ready_i(data_ready_i), .irq_o(irq_o), .dma_alloc_o(dma_alloc_o)
);

// *** dv/tbr_peer.sv ***
/*
 Peer device on the shared trigger lines and the bus clock line.
 Assumes pulled-up lines; the bench sets what the peer drives.
*/
`timescale 1ns/100ps
module tbr_peer (
    // Device side
    input wire logic [tbr_pkg::TBR_TRIG_LINES-1:0] dev_line_i,
    input wire logic [tbr_pkg::TBR_TRIG_LINES-1:0] dev_oe_i,
    input wire logic dev_clk_i,
    input wire logic dev_clk_oe_i,
    // Peer controls
    input wire logic [tbr_pkg::TBR_TRIG_LINES-1:0] peer_line_i,
    input wire logic [tbr_pkg::TBR_TRIG_LINES-1:0] peer_oe_i,
    input wire logic peer_clk_en_i,
    // Resolved levels
    output logic [tbr_pkg::TBR_TRIG_LINES-1:0] line_o,
    output logic clk_line_o
);
    import tbr_pkg::*;
    logic pclk = 1'b0;
    // The peer timebase stands still while the peer is not the master.
    initial begin
        #13;
        forever begin
            #80;
            if (peer_clk_en_i) begin
                pclk = ~pclk;
            end
        end
    end
    // A released line floats to its pull-up, never to a stale value.
    always_comb begin
        for (int i = 0; i < TBR_TRIG_LINES; i++) begin
            line_o[i] = dev_oe_i[i] ? dev_line_i[i] :
                peer_oe_i[i] ? peer_line_i[i] : 1'b1;
        end
        clk_line_o = dev_clk_oe_i ? dev_clk_i :
            peer_clk_en_i ? pclk : 1'b1;
    end
endmodule

// *** dv/tb.sv ***
/*
 Self-checking bench for the trigger bus and timebase router.
 Assumes the peer model resolves the shared lines and bus clock line.
*/
`timescale 1ns/100ps
module tb;
    import tbr_pkg::*;
    typedef struct {logic [4:0] src; logic fall; logic [2:0] act;} tbr_row_s;
    tbr_row_s rows [6] = '{'{5'h00, 1'h0, 3'h1}, '{5'h09, 1'h1, 3'h2},
        '{5'h0A, 1'h0, 3'h4}, '{5'h10, 1'h1, 3'h7}, '{5'h0D, 1'h0, 3'h2},
        '{5'h05, 1'h1, 3'h4}};
    logic clk_i = 0, srst_i = 1, psel = 0, penable = 0, pwrite = 0;
    logic iref = 0, bkp = 0, dready = 0, pclk_en = 0, mt_q = 0, bc_q = 0;
    logic pready, pslverr, err, bus_clk, bclk_o, bclk_oe, mtb;
    logic ai, ao, ct, irq;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [9:0] programmable_function_pin = 0;
    logic [6:0] itim = 0, pline = 0, poe = 0, line, tl_o, tl_oe;
    logic [1:0] dma;
    logic [11:0] ex;
    int bad_count = 0, comparisons = 0, n_ai = 0, n_ao = 0, n_ct = 0;
    int n_mt = 0, n_bc = 0, m0, a0, o0, c0;
    tbr_router u_tbr_router (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .trig_line_i(line), .trig_line_o(tl_o),
        .trig_line_oe_o(tl_oe), .bus_clk_i(bus_clk), .bus_clk_o(bclk_o),
        .bus_clk_oe_o(bclk_oe), .internal_reference_timebase_i(iref),
        .master_timebase_o(mtb), .backplane_present_i(bkp), .pfi_i(programmable_function_pin),
        .internal_timing_i(itim), .ai_trig_o(ai), .ao_trig_o(ao),
        .ctr_trig_o(ct), .data_ready_i(dready), .irq_o(irq),
        .dma_alloc_o(dma));
    tbr_peer u_tbr_peer (.dev_line_i(tl_o), .dev_oe_i(tl_oe),
        .dev_clk_i(bclk_o), .dev_clk_oe_i(bclk_oe), .peer_line_i(pline),
        .peer_oe_i(poe), .peer_clk_en_i(pclk_en), .line_o(line),
        .clk_line_o(bus_clk));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        forever #25 iref = ~iref;
    end
    always @(posedge clk_i) begin
        n_ai <= n_ai + ai;
        n_ao <= n_ao + ao;
        n_ct <= n_ct + ct;
        mt_q <= mtb;
        n_mt <= n_mt + (mtb !== mt_q);
        bc_q <= bus_clk;
        n_bc <= n_bc + (bus_clk !== bc_q);
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Holds the request until ready is sampled high, then releases it.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    function automatic logic [11:0] delta();
        return {4'(n_ct - c0), 4'(n_ao - o0), 4'(n_ai - a0)};
    endfunction
    initial begin
        #50000;
        bad_count++;
        final_report();
    end
    initial begin
        cyc(12);
        srst_i <= 0;
        cyc(1);
        #1;
        check({bclk_oe, irq, dma}, 0);
        apb(0, TBR_CLK_CTRL_OFS, 0);
        check(rd[1:0], 0);
        apb(0, TBR_XFER_OFS, 0);
        check(rd, TBR_XFER_RST);
        apb(0, 8'h40, 0);
        check(err, 1);
        itim <= 7'h55;
        apb(1, TBR_BUS_DRIVE_OFS, 32'h7F);
        apb(1, TBR_CLK_CTRL_OFS, 32'h2);
        cyc(6);
        check({tl_oe, bclk_oe}, 0);
        bkp <= 1;
        cyc(6);
        check({tl_oe, bclk_oe, tl_o}, {8'hFF, 7'h55});
        check(line, 7'h55);
        m0 = n_bc;
        cyc(200);
        check((n_bc - m0) inside {[31:33]}, 1);
        apb(1, TBR_CLK_CTRL_OFS, 32'h3);
        cyc(4);
        check(bclk_oe, 0);
        apb(1, TBR_BUS_DRIVE_OFS, 0);
        apb(1, TBR_CLK_CTRL_OFS, 32'h1);
        pclk_en <= 1;
        cyc(10);
        m0 = n_mt;
        cyc(200);
        check((n_mt - m0) inside {[9:11]}, 1);
        apb(1, TBR_CLK_CTRL_OFS, 0);
        cyc(10);
        m0 = n_mt;
        cyc(200);
        check((n_mt - m0) inside {[31:33]}, 1);
        pclk_en <= 0;
        poe <= 7'h7F;
        foreach (rows[i]) begin
            programmable_function_pin <= {10{rows[i].fall}};
            pline <= {7{rows[i].fall}};
            apb(1, TBR_TRIG_CTRL_OFS,
                {20'h0, rows[i].act, rows[i].fall, 3'h0, rows[i].src});
            ex = {3'h0, rows[i].act[2], 3'h0, rows[i].act[1],
                3'h0, rows[i].act[0]};
            cyc(8);
            a0 = n_ai;
            o0 = n_ao;
            c0 = n_ct;
            programmable_function_pin <= ~programmable_function_pin;
            pline <= ~pline;
            cyc(10);
            check(delta(), ex);
            programmable_function_pin <= ~programmable_function_pin;
            pline <= ~pline;
            cyc(10);
            check(delta(), ex);
        end
        apb(1, TBR_DMA_REQ_OFS, 1);
        apb(1, TBR_DMA_REQ_OFS, 1);
        cyc(2);
        check({err, dma}, 3'b011);
        apb(1, TBR_DMA_REQ_OFS, 1);
        cyc(2);
        check({err, dma}, 3'b111);
        apb(0, TBR_STATUS_OFS, 0);
        check(rd[TBR_ST_DMA_ERR_BIT], 1);
        check(rd[TBR_ST_TRIG_BIT], 1);
        apb(1, TBR_DMA_REL_OFS, 1);
        apb(1, TBR_DMA_REQ_OFS, 1);
        cyc(2);
        check({err, dma}, 3'b011);
        dready <= 1;
        cyc(3);
        check(irq, 0);
        apb(1, TBR_XFER_OFS, 1);
        cyc(3);
        check(irq, 1);
        dready <= 0;
        cyc(3);
        check(irq, 0);
        // Inverted pin 0 gives one pulse when the pin falls.
        apb(1, TBR_PFI_POL_OFS, 32'h1);
        apb(1, TBR_TRIG_CTRL_OFS, 32'h200);
        cyc(8);
        a0 = n_ai;
        o0 = n_ao;
        c0 = n_ct;
        programmable_function_pin <= 10'h000;
        cyc(10);
        check(delta(), 12'h001);
        // Level mode pulses on every cycle while the source stands high.
        apb(1, TBR_PFI_LEVEL_OFS, 32'h1);
        a0 = n_ai;
        cyc(10);
        check(n_ai - a0, 32'h9);
        apb(1, TBR_PFI_LEVEL_OFS, 32'h0);
        apb(1, TBR_STATUS_OFS, 32'h0003_0000);
        apb(0, TBR_STATUS_OFS, 0);
        check(rd[17:16], 2'h0);
        // A reset in mid-run must bring back the default setup.
        apb(1, TBR_CLK_CTRL_OFS, 32'h3);
        srst_i <= 1;
        cyc(2);
        srst_i <= 0;
        cyc(1);
        #1;
        check({bclk_oe, irq, dma, tl_oe}, 0);
        apb(0, TBR_CLK_CTRL_OFS, 0);
        check(rd[1:0], 0);
        apb(0, TBR_XFER_OFS, 0);
        check(rd, TBR_XFER_RST);
        final_report();
    end
endmodule
